// File: logic/cntmr_unit.v
// four-channel counter/timer with processor bus and daisy-chained vectored interrupts
// Function
// - after control word with bit 2 set, next channel write is the reload value.
// - reload byte covers 1..256; zero means 256.
// - new reload value waits until running counter reaches zero.
// - channel 0 write with bit 0 clear loads the vector register, unless a reload byte is owed to channel 0.
// - vector keeps bits 7..3; bits 2..1 carry the requesting channel number.
// - write is request and enable low with read high, latched at T3 edge.
// - read returns selected channel down-counter by T3 without wait states.
// - counter mode decrements on each synchronised active trigger edge.
// - zero-count output pulses right after the 1 to 0 step.
// - timer trigger starts timing on the second following clock edge.
// - zero count requests an interrupt only with the enable bit set.
// - an enabled channel requests on every zero count.
// - channel 0 highest priority; chain position sets device priority.
// - lower priority never interrupts higher priority still in service.
// - request status frozen while opcode fetch is active.
// - in acknowledge with chain-in active, top requester drives its vector.
// - return-from-irq bytes end service of the served channel, chain-out re-enabled.
`include "cntmr_regs.vh"
module cntmr_unit #(
	parameter CHANNELS = 4
) (
	// clock, reset, enable
	input  wire       sys_clk,
	input  wire       nrst,
	input  wire       clk_en,
	// processor bus
	input  wire       chip_enable_n,
	input  wire       io_request_n,
	input  wire       read_n,
	input  wire       opcode_fetch_n,
	input  wire       channel_select_lo,
	input  wire       channel_select_hi,
	input  wire [7:0] data_in,
	output reg  [7:0] data_out,
	output wire       data_oe,
	// interrupt daisy chain
	output wire       irq_n,
	input  wire       irq_chain_in,
	output wire       irq_chain_out,
	// channel pins
	input  wire [3:0] ext_count_trigger,
	output wire [3:0] zero_count_pulse
);

	// ********************
	// input synchronisers
	// ********************
	reg [3:0] trg_meta;
	reg [3:0] trg_sync;
	reg [5:0] bus_meta;
	reg [5:0] bus_sync;
	reg       iei_meta;
	reg       iei_sync;

	// pins come from outside the clock domain, two flops each
	always @(posedge sys_clk) begin
		if (!nrst) begin
			trg_meta <= 4'h0;
			trg_sync <= 4'h0;
			bus_meta <= 6'h3F;
			bus_sync <= 6'h3F;
			iei_meta <= 1'b0;
			iei_sync <= 1'b0;
		end else if (clk_en) begin
			trg_meta <= ext_count_trigger;
			trg_sync <= trg_meta;
			bus_meta <= {chip_enable_n, io_request_n, read_n, opcode_fetch_n, channel_select_hi, channel_select_lo};
			bus_sync <= bus_meta;
			iei_meta <= irq_chain_in;
			iei_sync <= iei_meta;
		end
	end

	wire       ce_n   = bus_sync[5];
	wire       io_request_n_n = bus_sync[4];
	wire       rd_n   = bus_sync[3];
	wire       m1_n   = bus_sync[2];
	wire [1:0] sel    = bus_sync[1:0];

	// ********************
	// bus cycle decode
	// ********************
	reg       cycle_seen;
	reg [7:0] wr_latch;
	reg [4:0] vector_base;
	reg       tc_due0;
	wire      io_active  = ~io_request_n_n & ~ce_n & m1_n;
	wire      wr_start   = io_active & rd_n & ~cycle_seen;
	wire      rd_active  = io_active & ~rd_n;
	wire      ack_active = ~io_request_n_n & ~m1_n;
	// a reload byte owed to channel 0 must not be mistaken for a vector
	wire      vec_write  = wr_start & (sel == 2'b00) & ~data_in[`CNTMR_CW_IS_CONTROL] & ~tc_due0;

	// one write per request, data captured on the first decode edge
	always @(posedge sys_clk) begin
		if (!nrst) begin
			cycle_seen  <= 1'b0;
			vector_base <= `CNTMR_VEC_RESET;
			tc_due0     <= 1'b0;
		end else if (clk_en) begin
			cycle_seen <= io_active;
			// mirrors the channel 0 reload expectation: set by control word, cleared by the next write
			if (wr_start && (sel == 2'b00))
				tc_due0 <= ~tc_due0 & data_in[`CNTMR_CW_IS_CONTROL] & data_in[`CNTMR_CW_TC_FOLLOWS];
			if (vec_write)
				vector_base <= data_in[7:3];
		end
	end

	// ********************
	// channels
	// ********************
	wire [7:0] cnt   [0:3];
	wire [3:0] zc;
	wire [3:0] ien;
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g = g + 1) begin : ch
			cntmr_channel u_ch (
				.sys_clk     (sys_clk),
				.nrst        (nrst),
				.clk_en      (clk_en),
				.wr_stb      (wr_start & (sel == g) & ~vec_write),
				.wr_data     (data_in),
				.trig_sync   (trg_sync[g]),
				.count_value (cnt[g]),
				.zero_pulse  (zc[g]),
				.irq_enable  (ien[g])
			);
		end
	endgenerate
	assign zero_count_pulse = zc;

	// ********************
	// interrupt logic
	// ********************
	reg  [3:0] pending;
	reg  [3:0] zc_hold;
	reg  [3:0] in_service;
	reg        return_from_irq_half;
	reg        return_from_irq_seen;
	reg        fetch_done;
	reg        ack_hold;
	reg  [1:0] grant_ch;
	reg        grant_ok;
	reg        blocked;
	integer    i;

	// fixed priority: lowest channel number wins; a lower channel may nest over a higher one in service
	always @* begin
		grant_ch = 2'b00;
		grant_ok = 1'b0;
		blocked  = 1'b0;
		for (i = 0; i < 4; i = i + 1) begin
			blocked = blocked | in_service[i];
			if (pending[i] && !blocked && !grant_ok) begin
				grant_ch = i[1:0];
				grant_ok = 1'b1;
			end
		end
	end

	// answered once per acknowledge; the vector then stands until the cycle ends
	wire ack_win      = ack_active & iei_sync & grant_ok & ~ack_hold;
	wire fetch_strobe = ~m1_n & ~rd_n & io_request_n_n & ~fetch_done;

	// pending set at zero count, frozen during opcode fetch
	always @(posedge sys_clk) begin
		if (!nrst) begin
			pending    <= 4'h0;
			zc_hold    <= 4'h0;
			in_service <= 4'h0;
			return_from_irq_half  <= 1'b0;
			return_from_irq_seen  <= 1'b0;
			fetch_done <= 1'b0;
			ack_hold   <= 1'b0;
		end else if (clk_en) begin
			fetch_done <= ~m1_n & ~rd_n;
			ack_hold   <= ack_active & (ack_hold | ack_win);
			// zero counts in a fetch are parked, not lost, until the fetch ends
			if (m1_n) begin
				pending <= pending | zc_hold | (zc & ien);
				zc_hold <= 4'h0;
			end else
				zc_hold <= zc_hold | (zc & ien);
			if (ack_win) begin
				pending[grant_ch]    <= 1'b0;
				in_service[grant_ch] <= 1'b1;
			end
			// watch opcode bytes for the two-byte return sequence
			if (fetch_strobe) begin
				if (return_from_irq_half && data_in == `CNTMR_RETURN_FROM_IRQ_SECOND && iei_sync) begin
					return_from_irq_seen <= 1'b1;
					return_from_irq_half <= 1'b0;
				end else
					return_from_irq_half <= (data_in == `CNTMR_RETURN_FROM_IRQ_FIRST);
			end
			// service ends once the fetch is over, so request status stays frozen through it
			if (return_from_irq_seen && m1_n) begin
				// clear only the highest-priority channel in service
				in_service <= in_service & (in_service - 4'h1);
				return_from_irq_seen  <= 1'b0;
			end
		end
	end

	assign irq_n         = ~(grant_ok & iei_sync);
	assign irq_chain_out = iei_sync & (pending == 4'h0) & (in_service == 4'h0);

	// ********************
	// read data and vector output
	// ********************
	assign data_oe = rd_active | ack_win | ack_hold;

	// data registered; vector carries channel code in bits 2..1
	always @(posedge sys_clk) begin
		if (!nrst)
			data_out <= 8'h00;
		else if (clk_en) begin
			if (ack_win)
				data_out <= {vector_base, grant_ch, 1'b0};
			else if (!ack_hold)
				data_out <= cnt[sel];
		end
	end

endmodule

// File: logic/cntmr_regs.vh
// register layout and timing constants of the four-channel counter/timer
`ifndef CNTMR_REGS_VH
`define CNTMR_REGS_VH
`define CNTMR_CW_IRQ_EN      7
`define CNTMR_CW_COUNTER     6
`define CNTMR_CW_PRESC256    5
`define CNTMR_CW_RISING      4
`define CNTMR_CW_TRIG_START  3
`define CNTMR_CW_TC_FOLLOWS  2
`define CNTMR_CW_SW_RESET    1
`define CNTMR_CW_IS_CONTROL  0
`define CNTMR_CW_RESET       8'h00
`define CNTMR_VEC_RESET      5'h00
`define CNTMR_TC_RESET       8'h00
`define CNTMR_PRESC16_LAST   8'h0F
`define CNTMR_PRESC256_LAST  8'hFF
`define CNTMR_RETURN_FROM_IRQ_FIRST     8'hED
`define CNTMR_RETURN_FROM_IRQ_SECOND    8'h4D
`endif

// File: logic/cntmr_channel.v
// one counter/timer channel: control word, reload value, prescaler and down-counter
`include "cntmr_regs.vh"
module cntmr_channel (
	// clock and reset
	input  wire       sys_clk,
	input  wire       nrst,
	input  wire       clk_en,
	// write strobe and data from the bus decoder
	input  wire       wr_stb,
	input  wire [7:0] wr_data,
	// synchronised trigger level
	input  wire       trig_sync,
	// status
	output reg  [7:0] count_value,
	output reg        zero_pulse,
	output wire       irq_enable
);

	reg [7:0] ctrl_word;
	reg [7:0] count_reload_value;
	reg       expect_tc;
	reg       running;
	reg       armed;
	reg       trig_prev;
	reg       start_pend;
	reg [7:0] presc;

	wire trig_edge = ctrl_word[`CNTMR_CW_RISING] ? (trig_sync & ~trig_prev) : (~trig_sync & trig_prev);
	wire counter_mode = ctrl_word[`CNTMR_CW_COUNTER];
	wire [7:0] presc_last = ctrl_word[`CNTMR_CW_PRESC256] ? `CNTMR_PRESC256_LAST : `CNTMR_PRESC16_LAST;
	wire tick = running & (counter_mode ? trig_edge : (presc == presc_last));
	assign irq_enable = ctrl_word[`CNTMR_CW_IRQ_EN];

	// register loads, start sequencing and counting
	always @(posedge sys_clk) begin
		if (!nrst) begin
			ctrl_word          <= `CNTMR_CW_RESET;
			count_reload_value <= `CNTMR_TC_RESET;
			expect_tc          <= 1'b0;
			running            <= 1'b0;
			armed              <= 1'b0;
			trig_prev          <= 1'b0;
			start_pend         <= 1'b0;
			presc              <= 8'h00;
			count_value        <= 8'h00;
			zero_pulse         <= 1'b0;
		end else if (clk_en) begin
			trig_prev  <= trig_sync;
			zero_pulse <= 1'b0;
			// timer start lands on the second clock after the trigger
			if (armed && trig_edge) begin
				armed      <= 1'b0;
				start_pend <= 1'b1;
			end
			if (start_pend) begin
				start_pend <= 1'b0;
				running    <= 1'b1;
				presc      <= 8'h00;
			end
			if (running && !counter_mode)
				presc <= (presc == presc_last) ? 8'h00 : presc + 8'h01;
			if (tick) begin
				// zero byte reloads as 256 since 8'h00 wraps a full cycle
				count_value <= count_value - 8'h01;
				if (count_value == 8'h01) begin
					zero_pulse  <= 1'b1;
					count_value <= count_reload_value;
				end
			end
			if (wr_stb) begin
				if (expect_tc) begin
					count_reload_value <= wr_data;
					expect_tc          <= 1'b0;
					// running channel keeps old count until it reaches zero
					if (!running) begin
						count_value <= wr_data;
						if (!counter_mode && ctrl_word[`CNTMR_CW_TRIG_START])
							armed <= 1'b1;
						else
							running <= 1'b1;
					end
				end else if (wr_data[`CNTMR_CW_IS_CONTROL]) begin
					ctrl_word <= wr_data;
					expect_tc <= wr_data[`CNTMR_CW_TC_FOLLOWS];
					if (wr_data[`CNTMR_CW_SW_RESET]) begin
						running    <= 1'b0;
						armed      <= 1'b0;
						start_pend <= 1'b0;
					end
				end
			end
		end
	end

endmodule

// File: tb/cntmr_sva.sv
// bus, chain and pulse assertions of the counter/timer unit
module cntmr_sva #(
	parameter CHANNELS = 4
) (
	// clock and reset
	input wire       sys_clk,
	input wire       nrst,
	input wire       clk_en,
	// processor bus
	input wire       chip_enable_n,
	input wire       io_request_n,
	input wire       read_n,
	input wire       opcode_fetch_n,
	input wire       channel_select_lo,
	input wire       channel_select_hi,
	input wire [7:0] data_in,
	input wire [7:0] data_out,
	input wire       data_oe,
	// chain and pins
	input wire       irq_n,
	input wire       irq_chain_in,
	input wire       irq_chain_out,
	input wire [3:0] ext_count_trigger,
	input wire [3:0] zero_count_pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// checks
	// ****
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// phases held four edges, long enough to clear the pin synchronisers
	sequence wr_held; (!io_request_n && !chip_enable_n && read_n && opcode_fetch_n) [*4]; endsequence
	sequence rd_held; (!io_request_n && !chip_enable_n && !read_n && opcode_fetch_n) [*4]; endsequence
	sequence ack_held; (!io_request_n && !opcode_fetch_n) [*4]; endsequence
	chk_write_no_drive: assert property (wr_held |-> !data_oe)
		else $error("bus driven in write");
	chk_read_drives: assert property (rd_held |-> data_oe)
		else $error("read not driven");
	chk_ack_vector: assert property (ack_held ##0 data_oe |-> !data_out[0])
		else $error("vector bit 0 set");
	// ack clears pending, so only plain fetches are expected to freeze
	chk_irq_frozen: assert property ((!opcode_fetch_n && io_request_n) [*4] |-> $stable(irq_n))
		else $error("request moved in fetch");
	chk_chain_blocked: assert property (!irq_chain_in [*4] |-> !irq_chain_out)
		else $error("chain out without chain in");
	chk_pending_blocks: assert property (!irq_n |-> !irq_chain_out)
		else $error("chain out while pending");
	chk_zero_single: assert property (|zero_count_pulse |=> (zero_count_pulse & $past(zero_count_pulse)) == 4'h0)
		else $error("zero pulse too long");
	chk_reset_quiet: assert property ($rose(nrst) |-> irq_n && !data_oe && !irq_chain_out)
		else $error("outputs active after reset");
endmodule
bind cntmr_unit cntmr_sva #(.CHANNELS(CHANNELS)) u_cntmr_sva (.sys_clk, .nrst, .clk_en, .chip_enable_n,
	.io_request_n, .read_n, .opcode_fetch_n, .channel_select_lo, .channel_select_hi, .data_in, .data_out,
	.data_oe, .irq_n, .irq_chain_in, .irq_chain_out, .ext_count_trigger, .zero_count_pulse);

// File: tb/cntmr_cpu.sv
// processor bus model: i/o cycles, acknowledge and return fetches
module cntmr_cpu (
	// clock and answer
	input  wire        sys_clk,
	input  wire  [7:0] data_out,
	// bus pins
	output logic       chip_enable_n,
	output logic       io_request_n,
	output logic       read_n,
	output logic       opcode_fetch_n,
	output logic       channel_select_lo,
	output logic       channel_select_hi,
	output logic [7:0] data_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// bus cycles
	// ****
	initial begin
		{chip_enable_n, io_request_n, read_n, opcode_fetch_n} = 4'hF;
		{channel_select_hi, channel_select_lo} = 2'h0;
		data_in = 8'h00;
	end
	// one i/o read, write or acknowledge; ack drives fetch low two clocks early
	task automatic cyc(input logic [1:0] ch, input logic rd, ack, input logic [7:0] d, output logic [7:0] q);
		repeat (2) @(negedge sys_clk);
		{channel_select_hi, channel_select_lo} = ch;
		read_n = rd;
		data_in = d;
		opcode_fetch_n = !ack;
		if (ack)
			repeat (2) @(negedge sys_clk);
		io_request_n = 1'b0;
		chip_enable_n = ack;
		repeat (ack ? 7 : 5) @(negedge sys_clk);
		q = data_out;
		{chip_enable_n, io_request_n, read_n, opcode_fetch_n} = 4'hF;
		data_in = ~d; // released bus must not show the old byte
	endtask
	// two-byte return fetch
	task automatic return_from_irq();
		for (int i = 0; i < 2; i++) begin
			@(negedge sys_clk);
			opcode_fetch_n = 1'b0;
			read_n = 1'b0;
			data_in = i ? 8'h4D : 8'hED;
			repeat (5) @(negedge sys_clk);
			opcode_fetch_n = 1'b1;
			read_n = 1'b1;
		end
	endtask
endmodule

// File: tb/cntmr_unit_test.sv
// self-checking bench of the counter/timer unit
module cntmr_unit_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic       sys_clk = 1'b0;
	logic       nrst = 1'b0;
	logic       clk_en = 1'b1;
	logic       irq_chain_in = 1'b1;
	logic [3:0] ext_count_trigger = 4'h0;
	logic [3:0] seen_zero = 4'h0;
	logic [7:0] q;
	int         err_count = 0;
	int         num_checks = 0;
	wire        chip_enable_n, io_request_n, read_n, opcode_fetch_n, channel_select_lo, channel_select_hi;
	wire        data_oe, irq_n, irq_chain_out;
	wire  [7:0] data_in, data_out;
	wire  [3:0] zero_count_pulse;
	// ****
	// harness
	// ****
	always #10 sys_clk = ~sys_clk;
	cntmr_unit u_cntmr_unit (.sys_clk, .nrst, .clk_en, .chip_enable_n, .io_request_n, .read_n, .opcode_fetch_n,
		.channel_select_lo, .channel_select_hi, .data_in, .data_out, .data_oe, .irq_n, .irq_chain_in,
		.irq_chain_out, .ext_count_trigger, .zero_count_pulse);
	cntmr_cpu u_cntmr_cpu (.sys_clk, .data_out, .chip_enable_n, .io_request_n, .read_n, .opcode_fetch_n,
		.channel_select_lo, .channel_select_hi, .data_in);
	// pulse is one cycle wide, so latch it for the sequence below
	always @(posedge sys_clk) seen_zero <= seen_zero | zero_count_pulse;
	task automatic check(input logic [7:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// trigger period of seven clocks, above the two-clock minimum
	task automatic trig(input int ch, n);
		repeat (n) begin
			@(negedge sys_clk);
			ext_count_trigger[ch] = 1'b1;
			repeat (3) @(negedge sys_clk);
			ext_count_trigger[ch] = 1'b0;
			repeat (3) @(negedge sys_clk);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ****
	// tests
	// ****
	initial begin
		repeat (10) @(negedge sys_clk);
		nrst = 1'b1;
		u_cntmr_cpu.cyc(2'h0, 1'b1, 1'b0, 8'hA8, q);
		u_cntmr_cpu.cyc(2'h1, 1'b1, 1'b0, 8'hD5, q);
		u_cntmr_cpu.cyc(2'h1, 1'b1, 1'b0, 8'h03, q);
		u_cntmr_cpu.cyc(2'h1, 1'b0, 1'b0, 8'h00, q);
		check(q, 8'h03);
		trig(1, 2);
		u_cntmr_cpu.cyc(2'h1, 1'b0, 1'b0, 8'h00, q);
		check(q, 8'h01);
		check({7'h00, seen_zero[1]}, 8'h00);
		trig(1, 1);
		check({7'h00, seen_zero[1]}, 8'h01);
		check({7'h00, irq_n}, 8'h00);
		u_cntmr_cpu.cyc(2'h0, 1'b1, 1'b1, 8'h00, q);
		check(q, 8'hAA);
		check({7'h00, irq_chain_out}, 8'h00);
		u_cntmr_cpu.return_from_irq();
		repeat (4) @(negedge sys_clk);
		check({7'h00, irq_chain_out}, 8'h01);
		irq_chain_in = 1'b0;
		repeat (5) @(negedge sys_clk);
		check({7'h00, irq_chain_out}, 8'h00);
		irq_chain_in = 1'b1;
		u_cntmr_cpu.cyc(2'h2, 1'b1, 1'b0, 8'h55, q);
		u_cntmr_cpu.cyc(2'h2, 1'b1, 1'b0, 8'h00, q);
		trig(2, 1);
		u_cntmr_cpu.cyc(2'h2, 1'b0, 1'b0, 8'h00, q);
		check(q, 8'hFF);
		u_cntmr_cpu.cyc(2'h2, 1'b1, 1'b0, 8'h55, q);
		u_cntmr_cpu.cyc(2'h2, 1'b1, 1'b0, 8'h05, q);
		trig(2, 1);
		u_cntmr_cpu.cyc(2'h2, 1'b0, 1'b0, 8'h00, q);
		check(q, 8'hFE);
		// channel 3 reaches zero with its interrupt disabled
		u_cntmr_cpu.cyc(2'h3, 1'b1, 1'b0, 8'h55, q);
		u_cntmr_cpu.cyc(2'h3, 1'b1, 1'b0, 8'h01, q);
		trig(3, 1);
		check({7'h00, seen_zero[3]}, 8'h01);
		check({7'h00, irq_n}, 8'h01);
		// channel 0 timer, trigger start, even reload byte must not become a vector
		u_cntmr_cpu.cyc(2'h0, 1'b1, 1'b0, 8'h1D, q);
		u_cntmr_cpu.cyc(2'h0, 1'b1, 1'b0, 8'h02, q);
		repeat (20) @(negedge sys_clk);
		u_cntmr_cpu.cyc(2'h0, 1'b0, 1'b0, 8'h00, q);
		check(q, 8'h02);
		trig(0, 1);
		repeat (10) @(negedge sys_clk);
		u_cntmr_cpu.cyc(2'h0, 1'b0, 1'b0, 8'h00, q);
		check(q, 8'h01);
		tally_and_finish();
	end
	// watchdog well beyond the few hundred cycles the tests take
	initial begin
		repeat (5000) @(posedge sys_clk);
		err_count++;
		tally_and_finish();
	end
endmodule
